// ===== common/esc_pkg.sv
package esc_pkg;
   // frame and command codes
   localparam int FRAME_BITS = 9;
   localparam logic [7:0] CMD_SRC_VOLT = 8'h04;
   localparam logic [7:0] CMD_INIT_PROG = 8'h08;
   localparam logic [7:0] CMD_INIT_WR = 8'h09;
   localparam logic [7:0] CMD_INIT_RD = 8'h0A;
   localparam logic [7:0] CMD_SOFT_START = 8'h0C;
   localparam logic [7:0] CMD_DEEP_SLEEP = 8'h10;
   // power-on defaults
   localparam logic [7:0] RST_POS_ONE = 8'h41;
   localparam logic [7:0] RST_POS_TWO = 8'hA8;
   localparam logic [7:0] RST_NEG = 8'h32;
   localparam logic [7:0] RST_PH1 = 8'h8B;
   localparam logic [7:0] RST_PH2 = 8'h9C;
   localparam logic [7:0] RST_PH3 = 8'h96;
   localparam logic [7:0] RST_DUR = 8'h0F;
   localparam logic [1:0] RST_SLEEP = 2'h0;
   localparam logic [7:0] RST_INIT_CODE = 8'h00;
   // programming time, cycles at 125 MHz
   localparam int CLK_MHZ = 125;
   localparam int PROG_TIME_US = 10;
   localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
   localparam int FIFO_DEPTH = 32;
   localparam int FIFO_WIDTH = 9;

   typedef struct packed {
      logic is_data;
      logic [7:0] value;
   } esc_frame_t;

   typedef struct packed {
      logic [7:0] pos_source_level_one;
      logic [7:0] pos_source_level_two;
      logic [7:0] neg_source_level;
   } esc_source_t;

   typedef struct packed {
      logic [7:0] phase1;
      logic [7:0] phase2;
      logic [7:0] phase3;
      logic [7:0] duration;
   } esc_boost_t;
endpackage

// ===== hdl/esc_fifo.sv
`timescale 1ns/1ns
module esc_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 32
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   input wire logic flush,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rd_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge mclk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else if (flush) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// ===== hdl/esc_front_end.sv
`timescale 1ns/1ns
// Summary of operation
// [RULE1] host ties data/command pin low
// [RULE2] nine-bit frame, flag then byte msb
// [RULE3] flag zero command, one data
// [RULE4] host sends command then flag-one units
// [RULE5] read bytes out on falling edges
// [RULE6] source voltage three bytes, defaults
// [RULE7] negative level codes 0Ah..3Ah even
// [RULE8] command 08 programs, busy held
// [RULE9] program only after clock enabled
// [RULE10] command 09 stores four bytes
// [RULE11] command 0A reads four bytes
// [RULE12] soft start four bytes, defaults
// [RULE13] bits 6:4 drive strength
// [RULE14] bits 3:0 min off time
// [RULE15] duration two bits per phase
// [RULE16] deep sleep byte, 00 normal
// [RULE17] 01 mode one, 11 mode two
// [RULE18] sleep keeps busy, reset exits
// [RULE19] host waits while busy
// [RULE20] only while select low
// [RULE21] extra parameters ignored
// [RULE22] reset restores defaults
module esc_front_end #(
   parameter int PROG_CYC = esc_pkg::PROG_CYCLES
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // link pins
   input wire logic sel_n,
   input wire logic sclk,
   input wire logic sdi,
   input wire logic dc_n,
   output logic sdo,
   output logic sdo_oe_n,
   output logic busy,
   // settings out
   output esc_pkg::esc_source_t source_cfg,
   output esc_pkg::esc_boost_t boost_cfg,
   output logic neg_level_valid,
   output logic [2:0] ph1_strength,
   output logic [3:0] ph1_off_time,
   output logic off_time_valid,
   output logic [1:0] ph1_dur,
   output logic [1:0] ph2_dur,
   output logic [1:0] ph3_dur,
   output logic [1:0] sleep_mode,
   output logic [31:0] init_code,
   // core status
   input wire logic internal_clock_on,
   output logic prog_start
);
   esc_pkg::esc_frame_t frame;
   esc_pkg::esc_frame_t ff_out;
   logic frame_valid;
   logic flag_seen;
   logic sdo_w;
   logic sel_idle;
   logic ff_valid;
   logic ff_in_ready;
   logic ff_ready;
   logic [7:0] cmd_q;
   logic [2:0] idx_q;
   logic rd_q;
   logic [7:0] rd_byte;
   logic [31:0] init_q;
   logic [31:0] prog_cnt_q;
   logic drv_q;
   logic ff_flush;
   esc_pkg::esc_source_t src_q;
   esc_pkg::esc_boost_t bst_q;
   logic [1:0] sleep_q;

   // sequencer states
   typedef enum logic [1:0] {ESC_IDLE, ESC_PROG, ESC_SLEEP} esc_state_t;
   esc_state_t st_q;

   function automatic logic neg_ok(input logic [7:0] c);
      neg_ok = !c[7] && !c[0] && c >= 8'h0A && c <= 8'h3A;
   endfunction

   function automatic logic off_ok(input logic [7:0] c);
      off_ok = c[3:0] >= 4'h4;
   endfunction

   esc_shifter u_shift (
      .mclk(mclk),
      .rst(rst),
      .sel_n_pin(sel_n),
      .sclk_pin(sclk),
      .sdi_pin(sdi),
      .rd_byte(rd_byte),
      .rd_active(rd_q),
      .frame_valid(frame_valid),
      .frame(frame),
      .flag_seen(flag_seen),
      .sdo_q(sdo_w),
      .sel_idle(sel_idle)
   );

   // frames queue while programming runs
   assign ff_ready = (st_q != ESC_PROG);
   // queued frames dropped in deep sleep
   assign ff_flush = (st_q == ESC_SLEEP);

   esc_fifo #(
      .WIDTH(esc_pkg::FIFO_WIDTH),
      .DEPTH(esc_pkg::FIFO_DEPTH)
   ) u_fifo (
      .mclk(mclk),
      .rst(rst),
      .flush(ff_flush),
      .in_valid(frame_valid),
      .in_ready(ff_in_ready),
      .in_data(frame),
      .out_valid(ff_valid),
      .out_ready(ff_ready),
      .out_data(ff_out)
   );

   // init code read byte select
   always_comb begin
      unique case (idx_q[1:0])
         2'd0: rd_byte = init_q[31:24];
         2'd1: rd_byte = init_q[23:16];
         2'd2: rd_byte = init_q[15:8];
         default: rd_byte = init_q[7:0];
      endcase
   end

   ////////////////////////////////////////////////////////////
   // command decode; the data/command pin is not read [RULE1]
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cmd_q <= '0;
         idx_q <= '0;
         rd_q <= 1'b0;
      end else if (st_q == ESC_SLEEP) begin
         rd_q <= 1'b0; // [RULE18]
      end else if (frame_valid && !frame.is_data) begin
         cmd_q <= frame.value; // [RULE3]
         idx_q <= '0;
         rd_q <= (frame.value == esc_pkg::CMD_INIT_RD); // [RULE11]
      end else if (sel_idle) begin
         rd_q <= 1'b0;
      end else if (frame_valid && cmd_q == esc_pkg::CMD_INIT_RD && idx_q != 3'h7) begin
         idx_q <= idx_q + 3'h1;
      end
   end

   ////////////////////////////////////////////////////////////
   // data line driven only for the eight read bits
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         drv_q <= 1'b0;
      end else if (sel_idle || frame_valid) begin
         drv_q <= 1'b0;
      end else if (flag_seen && rd_q) begin
         drv_q <= 1'b1; // [RULE5]
      end
   end

   ////////////////////////////////////////////////////////////
   // parameter storage from the queue [RULE21]
   logic [7:0] qcmd_q;
   logic [2:0] qidx_q;
   logic pop;
   assign pop = ff_valid && ff_ready && st_q == ESC_IDLE;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         qcmd_q <= '0;
         qidx_q <= '0;
         src_q <= {esc_pkg::RST_POS_ONE, esc_pkg::RST_POS_TWO, esc_pkg::RST_NEG}; // [RULE22]
         bst_q <= {esc_pkg::RST_PH1, esc_pkg::RST_PH2, esc_pkg::RST_PH3,
                   esc_pkg::RST_DUR};
         init_q <= {4{esc_pkg::RST_INIT_CODE}};
         sleep_q <= esc_pkg::RST_SLEEP;
      end else if (pop && !ff_out.is_data) begin
         qcmd_q <= ff_out.value;
         qidx_q <= '0;
      end else if (pop) begin
         if (qidx_q != 3'h7) begin
            qidx_q <= qidx_q + 3'h1;
         end
         unique case (qcmd_q)
            esc_pkg::CMD_SRC_VOLT: begin
               if (qidx_q == 3'd0) begin
                  src_q.pos_source_level_one <= ff_out.value; // [RULE6]
               end
               if (qidx_q == 3'd1) begin
                  src_q.pos_source_level_two <= ff_out.value;
               end
               if (qidx_q == 3'd2) begin
                  src_q.neg_source_level <= ff_out.value;
               end
            end
            esc_pkg::CMD_INIT_WR: begin
               if (qidx_q < 3'd4) begin
                  init_q <= {init_q[23:0], ff_out.value}; // [RULE10]
               end
            end
            esc_pkg::CMD_SOFT_START: begin
               if (qidx_q == 3'd0) begin
                  bst_q.phase1 <= ff_out.value; // [RULE12]
               end
               if (qidx_q == 3'd1) begin
                  bst_q.phase2 <= ff_out.value;
               end
               if (qidx_q == 3'd2) begin
                  bst_q.phase3 <= ff_out.value;
               end
               if (qidx_q == 3'd3) begin
                  bst_q.duration <= ff_out.value;
               end
            end
            esc_pkg::CMD_DEEP_SLEEP: begin
               if (qidx_q == 3'd0) begin
                  sleep_q <= ff_out.value[1:0]; // [RULE16]
               end
            end
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////
   // programming and sleep sequencing
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_q <= ESC_IDLE;
         prog_cnt_q <= '0;
         prog_start <= 1'b0;
      end else begin
         prog_start <= 1'b0;
         unique case (st_q)
            ESC_IDLE: begin
               if (pop && !ff_out.is_data && ff_out.value == esc_pkg::CMD_INIT_PROG
                   && internal_clock_on) begin // [RULE9]
                  st_q <= ESC_PROG; // [RULE8]
                  prog_cnt_q <= 32'(PROG_CYC);
                  prog_start <= 1'b1;
               end else if (sleep_q == 2'b01 || sleep_q == 2'b11) begin
                  st_q <= ESC_SLEEP; // [RULE17]
               end
            end
            ESC_PROG: begin
               if (prog_cnt_q <= 32'd1) begin
                  st_q <= ESC_IDLE;
               end else begin
                  prog_cnt_q <= prog_cnt_q - 32'd1;
               end
            end
            ESC_SLEEP: begin
               st_q <= ESC_SLEEP; // [RULE18]
            end
            default: begin
               st_q <= ESC_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////
   // registered link outputs
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         busy <= 1'b0;
         sdo <= 1'b0;
         sdo_oe_n <= 1'b1;
      end else begin
         // busy also while queue is full [RULE19]
         busy <= (st_q != ESC_IDLE) || !ff_in_ready; // [RULE8] [RULE18]
         sdo <= sdo_w;
         sdo_oe_n <= !(drv_q && rd_q && !sel_idle); // [RULE5]
      end
   end

   ////////////////////////////////////////////////////////////
   // registered settings
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         source_cfg <= '0;
         boost_cfg <= '0;
         neg_level_valid <= 1'b0;
         ph1_strength <= '0;
         ph1_off_time <= '0;
         off_time_valid <= 1'b0;
         ph1_dur <= '0;
         ph2_dur <= '0;
         ph3_dur <= '0;
         sleep_mode <= '0;
         init_code <= '0;
      end else begin
         source_cfg <= src_q;
         boost_cfg <= bst_q;
         neg_level_valid <= neg_ok(src_q.neg_source_level); // [RULE7]
         ph1_strength <= bst_q.phase1[6:4]; // [RULE13]
         ph1_off_time <= bst_q.phase1[3:0];
         off_time_valid <= off_ok(bst_q.phase1) && off_ok(bst_q.phase2)
                           && off_ok(bst_q.phase3); // [RULE14]
         ph1_dur <= bst_q.duration[1:0]; // [RULE15]
         ph2_dur <= bst_q.duration[3:2];
         ph3_dur <= bst_q.duration[5:4];
         sleep_mode <= sleep_q;
         init_code <= init_q;
      end
   end
endmodule

// ===== hdl/esc_shifter.sv
`timescale 1ns/1ns
module esc_shifter (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // link pins
   input wire logic sel_n_pin,
   input wire logic sclk_pin,
   input wire logic sdi_pin,
   // read data, loaded before the first falling edge
   input wire logic [7:0] rd_byte,
   input wire logic rd_active,
   // frame out
   output logic frame_valid,
   output esc_pkg::esc_frame_t frame,
   output logic flag_seen,
   output logic sdo_q,
   output logic sel_idle
);
   logic [2:0] sel_s_q;
   logic [2:0] clk_s_q;
   logic [1:0] dat_s_q;
   logic [8:0] sh_q;
   logic [3:0] cnt_q;
   logic [7:0] out_q;
   logic rise;
   logic fall;

   // second and third stages only are read
   assign rise = clk_s_q[1] && !clk_s_q[2];
   assign fall = !clk_s_q[1] && clk_s_q[2];
   assign sel_idle = sel_s_q[1];

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sel_s_q <= 3'h7;
         clk_s_q <= '0;
         dat_s_q <= '0;
      end else begin
         sel_s_q <= {sel_s_q[1:0], sel_n_pin};
         clk_s_q <= {clk_s_q[1:0], sclk_pin};
         dat_s_q <= {dat_s_q[0], sdi_pin};
      end
   end

   ////////////////////////////////////////////////////////////
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sh_q <= '0;
         cnt_q <= '0;
         frame_valid <= 1'b0;
         frame <= '0;
         flag_seen <= 1'b0;
      end else begin
         frame_valid <= 1'b0;
         flag_seen <= 1'b0;
         if (sel_s_q[1]) begin
            cnt_q <= '0; // [RULE20]
         end else if (rise) begin
            sh_q <= {sh_q[7:0], dat_s_q[1]}; // [RULE2]
            flag_seen <= (cnt_q == 4'h0) && dat_s_q[1]; // [RULE5]
            if (cnt_q == 4'(esc_pkg::FRAME_BITS - 1)) begin
               cnt_q <= '0;
               frame_valid <= 1'b1;
               frame <= {sh_q[7:0], dat_s_q[1]};
            end else begin
               cnt_q <= cnt_q + 4'h1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         out_q <= '0;
         sdo_q <= 1'b0;
      end else if (flag_seen && rd_active) begin
         out_q <= rd_byte;
      end else if (fall && rd_active && !sel_s_q[1] && cnt_q != 4'h0) begin
         sdo_q <= out_q[7]; // [RULE5]
         out_q <= {out_q[6:0], 1'b0};
      end
   end
endmodule

// ===== tb/esc_fe_asserts.sv
`timescale 1ns/1ns
module esc_fe_asserts (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // watched ports
   input wire logic sel_n,
   input wire logic sdo_oe_n,
   input wire logic busy,
   input wire logic prog_start,
   input wire logic neg_level_valid,
   input wire logic off_time_valid,
   input wire logic [2:0] ph1_strength,
   input wire logic [3:0] ph1_off_time,
   input wire logic [1:0] ph1_dur,
   input wire logic [1:0] ph2_dur,
   input wire logic [1:0] ph3_dur,
   input wire logic [1:0] sleep_mode,
   input wire esc_pkg::esc_source_t source_cfg,
   input wire esc_pkg::esc_boost_t boost_cfg
);
   default clocking @(posedge mclk);
   endclocking
   default disable iff (rst);
   a_phase_fields: assert property (
      $stable(boost_cfg) [*3] |-> {ph1_strength, ph1_off_time} == boost_cfg.phase1[6:0])
      else $error("phase one fields wrong");
   a_dur_fields: assert property (
      $stable(boost_cfg) [*3] |-> {ph3_dur, ph2_dur, ph1_dur} == boost_cfg.duration[5:0])
      else $error("duration fields wrong");
   a_neg_valid: assert property (
      $stable(source_cfg) [*3] |-> neg_level_valid == (!source_cfg.neg_source_level[7]
      && source_cfg.neg_source_level inside {[8'h0A:8'h3A]} && !source_cfg.neg_source_level[0]))
      else $error("negative level flag wrong");
   a_off_valid: assert property (
      $stable(boost_cfg) [*3] |-> off_time_valid == (boost_cfg.phase1[3:0] >= 4'h4
      && boost_cfg.phase2[3:0] >= 4'h4 && boost_cfg.phase3[3:0] >= 4'h4))
      else $error("off time flag wrong");
   a_sleep_busy: assert property (
      (sleep_mode[0] && $stable(sleep_mode)) [*3] |-> busy)
      else $error("busy low in deep sleep");
   a_prog_busy: assert property (
      prog_start |-> ##2 busy [*8])
      else $error("busy dropped while programming");
   a_oe_idle: assert property (
      sel_n [*5] |-> sdo_oe_n)
      else $error("data driven while deselected");
   a_reset_defaults: assert property (
      $fell(rst) |-> ##1 source_cfg == 24'h41_A832 && boost_cfg == 32'h8B9C_960F
      && sleep_mode == 2'h0)
      else $error("defaults missing after reset");
   c_prog: cover property (prog_start);
   c_read: cover property (!sdo_oe_n);
   c_sleep: cover property (sleep_mode == 2'h3);
endmodule
////////////////////////////////////////
bind esc_front_end esc_fe_asserts i_chk (
   .mclk(mclk), .rst(rst), .sel_n(sel_n), .sdo_oe_n(sdo_oe_n), .busy(busy),
   .prog_start(prog_start), .neg_level_valid(neg_level_valid),
   .off_time_valid(off_time_valid), .ph1_strength(ph1_strength),
   .ph1_off_time(ph1_off_time), .ph1_dur(ph1_dur), .ph2_dur(ph2_dur), .ph3_dur(ph3_dur),
   .sleep_mode(sleep_mode), .source_cfg(source_cfg), .boost_cfg(boost_cfg));

// ===== tb/esc_host_model.sv
`timescale 1ns/1ns
module esc_host_model (
   // clock
   input wire logic mclk,
   // link pins
   output logic sel_n,
   output logic sclk,
   output logic sdi,
   output logic dc_n,
   input wire logic sdo
);
   localparam int HALF = 8;
   // idle levels, called once at start
   task automatic idle();
      sel_n <= 1'b1;
      sclk <= 1'b0;
      sdi <= 1'b1;
      dc_n <= 1'b0;
   endtask
   ////////////////////////////////////////
   // select change, released data line flips
   task automatic sel(input logic v);
      @(posedge mclk);
      sel_n <= v;
      if (v)
         sdi <= ~sdi;
      repeat (HALF) @(posedge mclk);
   endtask
   // one nine-bit unit, read bits taken before each rise after the flag
   task automatic unit(input logic flag, input logic [7:0] b, output logic [7:0] rx);
      logic [8:0] w;
      w = {flag, b};
      rx = 8'h00;
      for (int i = 8; i >= 0; i--) begin
         sdi <= w[i];
         repeat (HALF) @(posedge mclk);
         if (i < 8)
            rx = {rx[6:0], sdo};
         sclk <= 1'b1;
         repeat (HALF) @(posedge mclk);
         sclk <= 1'b0;
      end
      repeat (HALF) @(posedge mclk);
   endtask
   // four bits then deselect
   task automatic stray();
      sel(1'b0);
      repeat (4) begin
         sdi <= ~sdi;
         repeat (HALF) @(posedge mclk);
         sclk <= 1'b1;
         repeat (HALF) @(posedge mclk);
         sclk <= 1'b0;
      end
      sel(1'b1);
   endtask
   // command unit, then n flag-one units
   task automatic cmd(input logic [7:0] c, input int n, input logic [39:0] p,
      output logic [39:0] rx);
      logic [7:0] r;
      rx = '0;
      sel(1'b0);
      unit(1'b0, c, r);
      for (int k = 0; k < n; k++) begin
         unit(1'b1, p[39-8*k -: 8], r);
         rx = {rx[31:0], r};
      end
      sel(1'b1);
   endtask
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ns
module tb;
   logic mclk, rst, sel_n, sclk, sdi, dc_n, sdo, sdo_oe_n, busy, prog_start;
   logic pulsed = 1'b0;
   // released data line reads inverted
   wire sdo_line = sdo_oe_n ? !sdo : sdo;
   logic neg_level_valid, off_time_valid, internal_clock_on;
   logic [2:0] ph1_strength;
   logic [3:0] ph1_off_time;
   logic [1:0] ph1_dur, ph2_dur, ph3_dur, sleep_mode, m;
   logic [31:0] init_code;
   logic [39:0] p, rx;
   logic [7:0] neg, r;
   logic [7:0] corner [6] = '{8'h0A, 8'h3A, 8'h3B, 8'h8A, 8'h3C, 8'h08};
   esc_pkg::esc_source_t source_cfg;
   esc_pkg::esc_boost_t boost_cfg;
   int miscompares = 0;
   int n_compared = 0;
   int busy_cyc = 0;
   integer seed = 11325;
   esc_front_end #(.PROG_CYC(20)) i_dut (
      .mclk(mclk), .rst(rst), .sel_n(sel_n), .sclk(sclk), .sdi(sdi), .dc_n(dc_n),
      .sdo(sdo), .sdo_oe_n(sdo_oe_n), .busy(busy), .source_cfg(source_cfg),
      .boost_cfg(boost_cfg), .neg_level_valid(neg_level_valid), .ph1_strength(ph1_strength),
      .ph1_off_time(ph1_off_time), .off_time_valid(off_time_valid), .ph1_dur(ph1_dur),
      .ph2_dur(ph2_dur), .ph3_dur(ph3_dur), .sleep_mode(sleep_mode), .init_code(init_code),
      .internal_clock_on(internal_clock_on), .prog_start(prog_start));
   esc_host_model i_host (.mclk(mclk), .sel_n(sel_n), .sclk(sclk), .sdi(sdi), .dc_n(dc_n),
      .sdo(sdo_line));
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      if (prog_start === 1'b1) begin
         pulsed <= 1'b1;
         busy_cyc <= 0;
      end else if (busy === 1'b1) begin
         busy_cyc <= busy_cyc + 1;
      end
   end
   ////////////////////////////////////////
   function automatic logic neg_ok(input logic [7:0] v);
      return !v[7] && v >= 8'h0A && v <= 8'h3A && !v[0];
   endfunction
   function automatic logic off_ok(input logic [31:0] b);
      return b[27:24] >= 4'h4 && b[19:16] >= 4'h4 && b[11:8] >= 4'h4;
   endfunction
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic wait_busy(input logic lvl, input int lim);
      int k;
      k = 0;
      while (busy !== lvl && k < lim) begin
         @(posedge mclk);
         k++;
      end
      chk(busy, lvl);
      if (busy !== lvl)
         wrap_up();
   endtask
   task automatic send(input logic [7:0] c, input int n, input logic [39:0] v);
      wait_busy(1'b0, 400);
      i_host.cmd(c, n, v, rx);
   endtask
   initial begin
      i_host.idle();
      rst = 1'b1;
      internal_clock_on = 1'b0;
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      repeat (4) @(posedge mclk);
      chk(source_cfg, 24'h41_A832);
      chk(boost_cfg, 32'h8B9C_960F);
      chk({busy, sleep_mode, init_code}, 35'h0);
      $display("test defaults done");
      for (int i = 0; i < 8; i++) begin
         neg = (i < 6) ? corner[i] : 8'($random(seed));
         p = {8'($random(seed)), 8'($random(seed)), neg, 16'($random(seed))};
         send(esc_pkg::CMD_SRC_VOLT, 4, p);
         chk(source_cfg, p[39:16]);
         chk(neg_level_valid, neg_ok(neg));
      end
      i_host.sel(1'b0);
      i_host.unit(1'b1, esc_pkg::CMD_SRC_VOLT, r);
      i_host.unit(1'b1, 8'h55, r);
      i_host.sel(1'b1);
      chk(source_cfg, p[39:16]);
      i_host.stray();
      i_host.unit(1'b0, esc_pkg::CMD_SRC_VOLT, r);
      i_host.unit(1'b1, 8'h00, r);
      chk(source_cfg, p[39:16]);
      $display("test source done");
      p = {$random(seed), 8'h00};
      send(esc_pkg::CMD_INIT_WR, 4, p);
      chk(init_code, p[39:8]);
      send(esc_pkg::CMD_INIT_RD, 4, 40'h0);
      chk(rx[31:0], p[39:8]);
      $display("test init code done");
      for (int i = 0; i < 6; i++) begin
         p = {1'b1, 7'($random(seed)), 1'b1, 7'($random(seed)), 1'b1, 7'($random(seed)),
            2'h0, 6'($random(seed)), 8'h00};
         p[19:16] = (i == 0) ? 4'h3 : p[19:16];
         p[35:32] = (i == 1) ? 4'h4 : p[35:32];
         send(esc_pkg::CMD_SOFT_START, 4, p);
         chk(boost_cfg, p[39:8]);
         chk({ph1_strength, ph1_off_time}, p[38:32]);
         chk({ph3_dur, ph2_dur, ph1_dur}, p[13:8]);
         chk(off_time_valid, off_ok(p[39:8]));
      end
      $display("test soft start done");
      send(esc_pkg::CMD_INIT_PROG, 0, 40'h0);
      repeat (30) @(posedge mclk);
      chk({pulsed, busy}, 2'h0);
      internal_clock_on <= 1'b1;
      send(esc_pkg::CMD_INIT_PROG, 0, 40'h0);
      wait_busy(1'b0, 200);
      chk({pulsed, busy_cyc >= 20}, 2'h3);
      $display("test program done");
      send(esc_pkg::CMD_DEEP_SLEEP, 1, {8'h02, 32'h0});
      chk({sleep_mode, busy}, 3'h4);
      for (int i = 0; i < 2; i++) begin
         m = i ? 2'h3 : 2'h1;
         send(esc_pkg::CMD_DEEP_SLEEP, 1, {6'h00, m, 32'h0});
         repeat (8) @(posedge mclk);
         chk({sleep_mode, busy}, {m, 1'b1});
         rst <= 1'b1;
         repeat (2) @(posedge mclk);
         rst <= 1'b0;
         repeat (4) @(posedge mclk);
         chk({source_cfg, busy}, {24'h41_A832, 1'b0});
      end
      $display("test deep sleep done");
      wrap_up();
   end
endmodule
